// ==== common/amtp_cfg.svh ====
// Offsets, field positions, reset values and codes of the mode and pattern registers.
//
// How it works
// R1 - Bit 14 merges two pairs onto one
// R2 - Register 1 bit 6 enables serial link
// R3 - Register 1 bit 5 disables parallel lanes
// R4 - Register 1 bit 0 powers everything down
// R5 - Mode select bits are 7, 4, 2
// R6 - Codes 111/011/000 give 8/16/32 inputs
// R7 - Software avoids serial link in 8-input mode
// R8 - Register 2 bits 15-13 pick frame pattern
// R9 - Register 2 bits 9-7 pick data pattern
// R10 - Pattern codes decode to eight named patterns
// R11 - Software sets custom or ramp before PRBS
// R12 - Register 2 bit 12 selects low latency
// R13 - Register 2 bit 11 enables two-channel averaging
// R14 - Register 2 bit 10 puts PRBS on frame
// R15 - Register 2 bit 6 puts PRBS on data
// R16 - Eight-bit sample delay starts offset correction
// R17 - Software writes zero to reserved bits
`ifndef AMTP_CFG_SVH
`define AMTP_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define AMTP_ADDR_MODE        8'h01
`define AMTP_ADDR_PATTERN     8'h02
`define AMTP_ADDR_DELAY_HI    8'h03

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define AMTP_RESET_VALUE      16'h0000
`define AMTP_MASK_MODE        16'h40F5
`define AMTP_MASK_PATTERN     16'hFFFF
`define AMTP_MASK_DELAY_HI    16'h0600

// ----------------------------------------------------------------------------
// Field positions, register 1
// ----------------------------------------------------------------------------
`define AMTP_BIT_DOUBLE_RATE  14
`define AMTP_BIT_MODE_SEL2    7
`define AMTP_BIT_SERIAL_EN    6
`define AMTP_BIT_LANES_DIS    5
`define AMTP_BIT_MODE_SEL1    4
`define AMTP_BIT_MODE_SEL0    2
`define AMTP_BIT_POWER_DOWN   0

// ----------------------------------------------------------------------------
// Field positions, registers 2 and 3
// ----------------------------------------------------------------------------
`define AMTP_FRAME_PAT_HI     15
`define AMTP_FRAME_PAT_LO     13
`define AMTP_BIT_LOW_LATENCY  12
`define AMTP_BIT_AVERAGING    11
`define AMTP_BIT_FRAME_PRBS   10
`define AMTP_DATA_PAT_HI      9
`define AMTP_DATA_PAT_LO      7
`define AMTP_BIT_DATA_PRBS    6
`define AMTP_DELAY_LO_HI      5
`define AMTP_DELAY_LO_LO      0
`define AMTP_DELAY_HI_HI      10
`define AMTP_DELAY_HI_LO      9

// ----------------------------------------------------------------------------
// Input mode codes
// ----------------------------------------------------------------------------
`define AMTP_MODE_CODE_8      3'h7
`define AMTP_MODE_CODE_16     3'h3
`define AMTP_MODE_CODE_32     3'h0

`endif

// ==== common/amtp_pkg.sv ====
// Types shared by the mode and pattern configuration block.
package amtp_pkg;

  // Test pattern driven on a line, encoded as the 3-bit register code.
  typedef enum logic [2:0] {
    AMTP_PAT_NORMAL = 3'h0,
    AMTP_PAT_SYNC   = 3'h1,
    AMTP_PAT_DESKEW = 3'h2,
    AMTP_PAT_CUSTOM = 3'h3,
    AMTP_PAT_ONES   = 3'h4,
    AMTP_PAT_TOGGLE = 3'h5,
    AMTP_PAT_ZEROS  = 3'h6,
    AMTP_PAT_RAMP   = 3'h7
  } amtp_pattern_e;

  // Decoded input mode, one-hot, with a code for unlisted selections.
  typedef enum logic [3:0] {
    AMTP_MODE_32      = 4'b0001,
    AMTP_MODE_16      = 4'b0010,
    AMTP_MODE_8       = 4'b0100,
    AMTP_MODE_INVALID = 4'b1000
  } amtp_input_mode_e;

  // States of the offset correction start timer.
  typedef enum logic [1:0] {
    AMTP_DLY_IDLE = 2'b01,
    AMTP_DLY_WAIT = 2'b10
  } amtp_delay_state_e;

endpackage

// ==== hdl/amtp_top.sv ====
// Mode, interface, test pattern and offset delay configuration registers.
`timescale 1ns/1ns
`include "amtp_cfg.svh"

module amtp_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  // Register port from the serial control decoder
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [15:0]       reg_wdata_i,
  output logic      [15:0]       reg_rdata_o,
  output logic                   reg_rvalid_o,
  // Sample timing and trigger pin
  input  wire logic              sample_tick_i,
  input  wire logic              transmit_trigger_i,
  // Interface and power controls
  output logic                   double_rate_pair_merge_o,
  output logic                   serial_link_enable_o,
  output logic                   parallel_lanes_disable_o,
  output logic                   full_power_down_o,
  output logic [3:0]             input_mode_o,
  output logic                   mode_conflict_o,
  // Test pattern and processing controls
  output logic [2:0]             frame_line_pattern_code_o,
  output logic [2:0]             data_line_pattern_code_o,
  output logic                   frame_line_prbs_enable_o,
  output logic                   all_data_prbs_enable_o,
  output logic                   low_latency_o,
  output logic                   two_channel_averaging_o,
  // Offset correction
  output logic [7:0]             offset_fix_start_delay_o,
  output logic                   offset_fix_start_o,
  output logic                   offset_fix_pending_o
);

  // ----------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------
  logic [15:0] mode_reg_r;      // Input mode, interfaces and power-down.
  logic [15:0] pattern_reg_r;   // Patterns, latency, averaging, low delay bits.
  logic [15:0] delay_hi_reg_r;  // Only the top two delay bits are held here.

  // Write strobes, one per register.
  logic wr_mode;
  logic wr_pattern;
  logic wr_delay_hi;

  assign wr_mode     = reg_wr_i && (reg_addr_i == ADDR_W'(`AMTP_ADDR_MODE));
  assign wr_pattern  = reg_wr_i && (reg_addr_i == ADDR_W'(`AMTP_ADDR_PATTERN));
  assign wr_delay_hi = reg_wr_i && (reg_addr_i == ADDR_W'(`AMTP_ADDR_DELAY_HI));

  // Register 1. Reserved bits are masked off, so a careless nonzero write
  // cannot reach any decoded control and they always read back as zero.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_reg_r <= `AMTP_RESET_VALUE;
    end else if (wr_mode) begin
      mode_reg_r <= reg_wdata_i & `AMTP_MASK_MODE; // [R17]
    end
  end

  // Register 2. Every bit is a field, so the whole word is kept.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pattern_reg_r <= `AMTP_RESET_VALUE;
    end else if (wr_pattern) begin
      pattern_reg_r <= reg_wdata_i & `AMTP_MASK_PATTERN;
    end
  end

  // Register 3. Only the offset delay top bits belong to this block; the
  // rest of that register is owned elsewhere and reads zero here.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      delay_hi_reg_r <= `AMTP_RESET_VALUE;
    end else if (wr_delay_hi) begin
      delay_hi_reg_r <= reg_wdata_i & `AMTP_MASK_DELAY_HI;
    end
  end

  // ----------------------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------------------
  // Reads answer one cycle after the request; unmapped offsets read zero.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (reg_addr_i == ADDR_W'(`AMTP_ADDR_MODE)) begin
          reg_rdata_o <= mode_reg_r;
        end else if (reg_addr_i == ADDR_W'(`AMTP_ADDR_PATTERN)) begin
          reg_rdata_o <= pattern_reg_r;
        end else if (reg_addr_i == ADDR_W'(`AMTP_ADDR_DELAY_HI)) begin
          reg_rdata_o <= delay_hi_reg_r;
        end else begin
          reg_rdata_o <= 16'h0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------------------
  logic [2:0] mode_code;   // Select bits gathered most significant first.
  logic [7:0] delay_full;  // Full offset correction delay.

  assign mode_code = {mode_reg_r[`AMTP_BIT_MODE_SEL2],
                      mode_reg_r[`AMTP_BIT_MODE_SEL1],
                      mode_reg_r[`AMTP_BIT_MODE_SEL0]}; // [R5]

  assign delay_full = {delay_hi_reg_r[`AMTP_DELAY_HI_HI:`AMTP_DELAY_HI_LO],
                       pattern_reg_r[`AMTP_DELAY_LO_HI:`AMTP_DELAY_LO_LO]}; // [R16]

  // Input mode decode. Codes outside the three listed ones are flagged as
  // invalid rather than guessed, so downstream logic can hold off.
  amtp_pkg::amtp_input_mode_e mode_dec;

  always_comb begin
    unique case (mode_code)
      `AMTP_MODE_CODE_8:  mode_dec = amtp_pkg::AMTP_MODE_8;  // [R6]
      `AMTP_MODE_CODE_16: mode_dec = amtp_pkg::AMTP_MODE_16; // [R6]
      `AMTP_MODE_CODE_32: mode_dec = amtp_pkg::AMTP_MODE_32; // [R6]
      default:            mode_dec = amtp_pkg::AMTP_MODE_INVALID;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Interface and power controls
  // ----------------------------------------------------------------------------
  // Controls follow the registers with one cycle of lag so that every
  // output leaves a flip-flop.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      double_rate_pair_merge_o <= 1'b0;
      serial_link_enable_o     <= 1'b0;
      parallel_lanes_disable_o <= 1'b0;
      full_power_down_o        <= 1'b0;
      input_mode_o             <= amtp_pkg::AMTP_MODE_32;
    end else begin
      double_rate_pair_merge_o <= mode_reg_r[`AMTP_BIT_DOUBLE_RATE]; // [R1]
      serial_link_enable_o     <= mode_reg_r[`AMTP_BIT_SERIAL_EN];   // [R2]
      parallel_lanes_disable_o <= mode_reg_r[`AMTP_BIT_LANES_DIS];   // [R3]
      full_power_down_o        <= mode_reg_r[`AMTP_BIT_POWER_DOWN];  // [R4]
      input_mode_o             <= mode_dec;                          // [R6]
    end
  end

  // The serial link is not supported with 8 inputs. Software must not ask for
  // it; the block only reports the conflict and leaves the enable as written.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_conflict_o <= 1'b0;
    end else begin
      mode_conflict_o <= mode_reg_r[`AMTP_BIT_SERIAL_EN] &&
                         (mode_dec == amtp_pkg::AMTP_MODE_8); // [R7]
    end
  end

  // ----------------------------------------------------------------------------
  // Test patterns and processing
  // ----------------------------------------------------------------------------
  // The pattern codes pass out as their 3-bit encoding, whose values are the
  // pattern enum of the package.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_line_pattern_code_o <= amtp_pkg::AMTP_PAT_NORMAL;
      data_line_pattern_code_o  <= amtp_pkg::AMTP_PAT_NORMAL;
      frame_line_prbs_enable_o  <= 1'b0;
      all_data_prbs_enable_o    <= 1'b0;
      low_latency_o             <= 1'b0;
      two_channel_averaging_o   <= 1'b0;
    end else begin
      frame_line_pattern_code_o <=
        pattern_reg_r[`AMTP_FRAME_PAT_HI:`AMTP_FRAME_PAT_LO]; // [R8] [R10]
      data_line_pattern_code_o  <=
        pattern_reg_r[`AMTP_DATA_PAT_HI:`AMTP_DATA_PAT_LO];   // [R9] [R10]
      frame_line_prbs_enable_o  <= pattern_reg_r[`AMTP_BIT_FRAME_PRBS]; // [R14]
      all_data_prbs_enable_o    <= pattern_reg_r[`AMTP_BIT_DATA_PRBS];  // [R15]
      low_latency_o             <= pattern_reg_r[`AMTP_BIT_LOW_LATENCY]; // [R12]
      two_channel_averaging_o   <= pattern_reg_r[`AMTP_BIT_AVERAGING];  // [R13]
    end
  end

  // ----------------------------------------------------------------------------
  // Offset correction start
  // ----------------------------------------------------------------------------
  // The trigger is a pin, so it passes two flops before the edge detector.
  logic trig_meta_r;  // First synchroniser stage.
  logic trig_sync_r;  // Second synchroniser stage.
  logic trig_prev_r;  // Previous synchronised level for edge detect.
  logic trig_rise;    // One-cycle pulse on a rising trigger.

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_meta_r <= 1'b0;
      trig_sync_r <= 1'b0;
      trig_prev_r <= 1'b0;
    end else begin
      trig_meta_r <= transmit_trigger_i;
      trig_sync_r <= trig_meta_r;
      trig_prev_r <= trig_sync_r;
    end
  end

  assign trig_rise = trig_sync_r && !trig_prev_r;

  // Delay value mirrored out for the correction engine.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      offset_fix_start_delay_o <= 8'h00;
    end else begin
      offset_fix_start_delay_o <= delay_full; // [R16]
    end
  end

  // Timer is held off in full power-down, when nothing converts.
  amtp_trig_delay #(
    .DELAY_W (8)
  ) u_trig_delay (
    .ref_clk_i      (ref_clk_i),
    .reset_n_i      (reset_n_i),
    .trigger_rise_i (trig_rise),
    .sample_tick_i  (sample_tick_i),
    .enable_i       (!mode_reg_r[`AMTP_BIT_POWER_DOWN]), // [R4]
    .delay_i        (delay_full),
    .start_o        (offset_fix_start_o),
    .busy_o         (offset_fix_pending_o)
  );

endmodule

// ==== hdl/amtp_trig_delay.sv ====
// Timer that starts offset correction a set number of samples after the trigger.
`timescale 1ns/1ns
`include "amtp_cfg.svh"

module amtp_trig_delay #(
  parameter int DELAY_W = 8
) (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_n_i,
  // Control
  input  wire logic               trigger_rise_i,
  input  wire logic               sample_tick_i,
  input  wire logic               enable_i,
  input  wire logic [DELAY_W-1:0] delay_i,
  // Result
  output logic                    start_o,
  output logic                    busy_o
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  amtp_pkg::amtp_delay_state_e state_r;   // Timer state.
  logic [DELAY_W-1:0]          remain_r;  // Sample periods still to wait.

  // Trigger loads the delay; each sample tick counts one down. A trigger
  // during a wait restarts it, since only the latest pulse is meaningful.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r  <= amtp_pkg::AMTP_DLY_IDLE;
      remain_r <= '0;
      start_o  <= 1'b0;
    end else begin
      start_o <= 1'b0;
      if (!enable_i) begin
        // Power-down abandons any pending start.
        state_r <= amtp_pkg::AMTP_DLY_IDLE;
      end else if (trigger_rise_i) begin
        remain_r <= delay_i; // [R16]
        state_r  <= amtp_pkg::AMTP_DLY_WAIT;
      end else begin
        unique case (state_r)
          amtp_pkg::AMTP_DLY_IDLE: begin
            remain_r <= remain_r;
          end
          amtp_pkg::AMTP_DLY_WAIT: begin
            // A zero delay starts on the first tick after the trigger.
            if (sample_tick_i) begin
              if (remain_r == '0) begin
                start_o <= 1'b1; // [R16]
                state_r <= amtp_pkg::AMTP_DLY_IDLE;
              end else begin
                remain_r <= remain_r - 1'b1;
              end
            end
          end
          default: begin
            state_r <= amtp_pkg::AMTP_DLY_IDLE;
          end
        endcase
      end
    end
  end

  // Busy flag, registered so it shows the wait from the cycle after the trigger.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= enable_i && (trigger_rise_i ||
                (state_r == amtp_pkg::AMTP_DLY_WAIT &&
                 !(sample_tick_i && remain_r == '0)));
    end
  end

endmodule

// ==== tb/amtp_top_chk.sv ====
// Port-level assertions for the mode and pattern configuration block.
`timescale 1ns/1ns

module amtp_top_chk #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and register port
  input wire logic              ref_clk_i,
  input wire logic              reset_n_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0]       reg_wdata_i,
  input wire logic [15:0]       reg_rdata_o,
  // Interface and power controls
  input wire logic              double_rate_pair_merge_o,
  input wire logic              serial_link_enable_o,
  input wire logic              parallel_lanes_disable_o,
  input wire logic              full_power_down_o,
  input wire logic [3:0]        input_mode_o,
  // Pattern and processing controls
  input wire logic [2:0]        frame_line_pattern_code_o,
  input wire logic [2:0]        data_line_pattern_code_o,
  input wire logic              frame_line_prbs_enable_o,
  input wire logic              all_data_prbs_enable_o,
  input wire logic              low_latency_o,
  input wire logic              two_channel_averaging_o,
  // Offset correction
  input wire logic [7:0]        offset_fix_start_delay_o,
  input wire logic              offset_fix_start_o,
  input wire logic              offset_fix_pending_o
);
  // All checks live in the one register clock domain.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Decoded controls follow a write two edges after it is taken.
  sequence wr_mode_s; reg_wr_i && reg_addr_i == 1; endsequence
  sequence wr_pat_s; reg_wr_i && reg_addr_i == 2; endsequence
  sequence wr_hi_s; reg_wr_i && reg_addr_i == 3; endsequence

  // One-hot input mode expected from the three scattered select bits.
  function automatic logic [3:0] mode_of(input logic [15:0] w);
    case ({w[7], w[4], w[2]})
      3'b111:  return 4'b0100;
      3'b011:  return 4'b0010;
      3'b000:  return 4'b0001;
      default: return 4'b1000;
    endcase
  endfunction

  merge_bit_a: assert property (wr_mode_s |-> ##2
    double_rate_pair_merge_o == $past(reg_wdata_i[14], 2)) else $error("merge bit wrong");
  serial_bit_a: assert property (wr_mode_s |-> ##2
    serial_link_enable_o == $past(reg_wdata_i[6], 2)) else $error("serial enable wrong");
  lanes_bit_a: assert property (wr_mode_s |-> ##2
    parallel_lanes_disable_o == $past(reg_wdata_i[5], 2)) else $error("lane disable wrong");
  power_bit_a: assert property (wr_mode_s |-> ##2
    full_power_down_o == $past(reg_wdata_i[0], 2)) else $error("power down wrong");
  mode_decode_a: assert property (wr_mode_s |-> ##2
    input_mode_o == mode_of($past(reg_wdata_i, 2))) else $error("input mode wrong");
  frame_pat_a: assert property (wr_pat_s |-> ##2
    frame_line_pattern_code_o == $past(reg_wdata_i[15:13], 2)) else $error("frame code wrong");
  data_pat_a: assert property (wr_pat_s |-> ##2
    data_line_pattern_code_o == $past(reg_wdata_i[9:7], 2)) else $error("data code wrong");
  lat_avg_a: assert property (wr_pat_s |-> ##2 {low_latency_o,
    two_channel_averaging_o} == $past(reg_wdata_i[12:11], 2)) else $error("latency bits wrong");
  prbs_sel_a: assert property (wr_pat_s |-> ##2 {frame_line_prbs_enable_o,
    all_data_prbs_enable_o} == $past({reg_wdata_i[10], reg_wdata_i[6]}, 2))
    else $error("prbs enables wrong");
  delay_low_a: assert property (wr_pat_s |-> ##2
    offset_fix_start_delay_o[5:0] == $past(reg_wdata_i[5:0], 2)) else $error("delay low wrong");
  delay_high_a: assert property (wr_hi_s |-> ##2
    offset_fix_start_delay_o[7:6] == $past(reg_wdata_i[10:9], 2)) else $error("delay high wrong");
  start_pulse_a: assert property (offset_fix_start_o |->
    $past(offset_fix_pending_o) && !$past(offset_fix_start_o)) else $error("start pulse wrong");
  pd_timer_a: assert property (full_power_down_o && $past(full_power_down_o) |->
    !offset_fix_pending_o && !offset_fix_start_o) else $error("timer runs in power down");
  unmapped_rd_a: assert property (reg_rd_i && !(reg_addr_i inside {1, 2, 3}) |=>
    reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
endmodule

// ==== tb/amtp_top_tb.sv ====
// Self-checking bench for the mode, pattern and offset delay registers.
`timescale 1ns/1ns

module amtp_top_tb;
  // --------------------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------------------
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        sample_tick_i = 1'b0;
  logic        transmit_trigger_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [3:0]  input_mode_o;
  logic [2:0]  frame_line_pattern_code_o, data_line_pattern_code_o;
  logic [7:0]  offset_fix_start_delay_o;
  logic        reg_rvalid_o, double_rate_pair_merge_o, serial_link_enable_o;
  logic        parallel_lanes_disable_o, full_power_down_o, mode_conflict_o;
  logic        frame_line_prbs_enable_o, all_data_prbs_enable_o, low_latency_o;
  logic        two_channel_averaging_o, offset_fix_start_o, offset_fix_pending_o;
  int          num_errors = 0;
  int          compares = 0;
  // Grouped views keep each comparison to one call.
  wire  [8:0]  ctl = {mode_conflict_o, double_rate_pair_merge_o, serial_link_enable_o,
                      parallel_lanes_disable_o, full_power_down_o, input_mode_o};
  wire  [9:0]  pat = {frame_line_pattern_code_o, data_line_pattern_code_o,
                      frame_line_prbs_enable_o, all_data_prbs_enable_o,
                      low_latency_o, two_channel_averaging_o};

  amtp_top DUT (
    .ref_clk_i, .reset_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_rvalid_o, .sample_tick_i, .transmit_trigger_i,
    .double_rate_pair_merge_o, .serial_link_enable_o, .parallel_lanes_disable_o,
    .full_power_down_o, .input_mode_o, .mode_conflict_o, .frame_line_pattern_code_o,
    .data_line_pattern_code_o, .frame_line_prbs_enable_o, .all_data_prbs_enable_o,
    .low_latency_o, .two_channel_averaging_o, .offset_fix_start_delay_o,
    .offset_fix_start_o, .offset_fix_pending_o
  );

  // 100 ns period for the 10 MHz reference clock.
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Four-state comparison so an unknown output never counts as a match.
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Inputs change 10 ns after the edge so the design samples them cleanly.
  task automatic step();
    @(posedge ref_clk_i);
    #10;
  endtask

  // One-cycle write strobe; one more edge lets the decoded outputs land.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    step();
    reg_wr_i = 1'b0;
    step();
  endtask

  // One-cycle read strobe, then a bounded wait for the answer.
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    int n;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    step();
    reg_rd_i = 1'b0;
    n = 0;
    while (reg_rvalid_o !== 1'b1 && n < 4) begin
      step();
      n++;
    end
    if (n == 4) begin
      num_errors++;
      conclude();
    end
    cmp("read data", exp, reg_rdata_o);
    // An idle edge keeps a following read from re-raising the strobe at once.
    step();
  endtask

  // Expected one-hot input mode from the select bits of a stored word.
  function automatic logic [3:0] mode_of(input logic [15:0] w);
    case ({w[7], w[4], w[2]})
      3'b111:  return 4'b0100;
      3'b011:  return 4'b0010;
      3'b000:  return 4'b0001;
      default: return 4'b1000;
    endcase
  endfunction

  // Raises the trigger and counts sample ticks seen while the timer waits.
  task automatic run_timer(input logic [7:0] d, input logic pd);
    int n;
    int ticks;
    int lim;
    wr(8'h02, {10'h000, d[5:0]});
    wr(8'h03, {5'h00, d[7:6], 9'h000});
    wr(8'h01, {15'h0000, pd});
    lim = pd ? 40 : 400;
    ticks = 0;
    n = 0;
    transmit_trigger_i = 1'b1;
    while (offset_fix_start_o !== 1'b1 && n < lim) begin
      if (offset_fix_pending_o === 1'b1 && n[0]) ticks++;
      sample_tick_i = n[0];
      step();
      n++;
    end
    sample_tick_i = 1'b0;
    transmit_trigger_i = 1'b0;
    if (!pd && n == lim) begin
      num_errors++;
      conclude();
    end
    cmp("ticks to start", pd ? 16'h0000 : 16'(d) + 16'h0001, 16'(ticks));
    repeat (4) step();
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  logic [15:0] mtab [8] = '{16'h0041, 16'h4000, 16'h0020, 16'h00D4,
                            16'h0014, 16'h0084, 16'hFFFF, 16'h0000};
  logic [15:0] m;
  logic [2:0]  c;

  initial begin
    repeat (8) @(posedge ref_clk_i);
    #10;
    reset_n_i = 1'b1;
    cmp("mode controls", 16'h0001, {7'h00, ctl});
    cmp("pattern controls", 16'h0000, {6'h00, pat});
    cmp("start delay", 16'h0000, {8'h00, offset_fix_start_delay_o});
    rd(8'h01, 16'h0000);
    rd(8'h02, 16'h0000);
    $display("test reset done");
    // Every mode code, each interface bit and the reserved bits of register 1.
    foreach (mtab[i]) begin
      wr(8'h01, mtab[i]);
      m = mtab[i] & 16'h40F5;
      cmp("mode controls", {7'h00, m[6] && mode_of(m) == 4'b0100, m[14], m[6], m[5], m[0],
          mode_of(m)}, {7'h00, ctl});
      rd(8'h01, m);
    end
    $display("test mode register done");
    // Every frame and data pattern code, with the single-bit fields varied.
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      // PRBS is asked for only while that line shows the custom or ramp code.
      m = {c, c[0], c[1], &c[1:0], ~c, ~|c[1:0], c, ~c};
      wr(8'h02, m);
      cmp("pattern controls", {6'h00, c, ~c, &c[1:0], ~|c[1:0], c[0], c[1]},
          {6'h00, pat});
      cmp("start delay low", {10'h000, c, ~c}, {10'h000, offset_fix_start_delay_o[5:0]});
      rd(8'h02, m);
    end
    $display("test pattern register done");
    // Upper delay bits live in register 3; unmapped places are refused.
    wr(8'h03, 16'hFFFF);
    rd(8'h03, 16'h0600);
    cmp("start delay high", 16'h0003, {14'h0000, offset_fix_start_delay_o[7:6]});
    wr(8'h04, 16'hFFFF);
    wr(8'hFF, 16'hFFFF);
    rd(8'h04, 16'h0000);
    rd(8'h00, 16'h0000);
    rd(8'h01, 16'h0000);
    rd(8'h03, 16'h0600);
    $display("test delay and unmapped done");
    // Offset correction timer at zero delay, at a delay of 8'h81 and under power down.
    run_timer(8'h00, 1'b0);
    run_timer(8'h81, 1'b0);
    run_timer(8'h05, 1'b1);
    $display("test offset timer done");
    conclude();
  end
endmodule

bind amtp_top amtp_top_chk #(.ADDR_W(ADDR_W)) chk (
  .ref_clk_i, .reset_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .double_rate_pair_merge_o, .serial_link_enable_o, .parallel_lanes_disable_o,
  .full_power_down_o, .input_mode_o, .frame_line_pattern_code_o, .data_line_pattern_code_o,
  .frame_line_prbs_enable_o, .all_data_prbs_enable_o, .low_latency_o,
  .two_channel_averaging_o, .offset_fix_start_delay_o, .offset_fix_start_o,
  .offset_fix_pending_o
);
